/* verilog/drsq_ref_select.sv */
// Reference priority selection, qualification, oscillator check and phase slew for one DPLL
`timescale 1ns/1ps

module drsq_ref_select (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [drsq_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [drsq_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [drsq_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [drsq_pkg::NUM_REFS*drsq_pkg::NUM_MONS-1:0] mon_flags_raw,
	input wire logic osc_in_range,
	input wire logic man_sel_pin,
	input wire logic history_valid,
	input wire logic refs_freq_locked,
	input wire logic signed [drsq_pkg::SLEW_W-1:0] phase_target,
	output logic [drsq_pkg::NUM_REFS*drsq_pkg::NUM_MONS-1:0] mon_status_pins,
	output logic sel_idx_pin,
	output logic sel_active_pin,
	output logic [1:0] loop_state,
	output logic [drsq_pkg::NUM_REFS-1:0] ref_qualified,
	output logic osc_input_loss_flag,
	output logic osc_valid,
	output logic hitless_enable,
	output logic slew_active,
	output logic signed [drsq_pkg::SLEW_W-1:0] phase_out
);
	import drsq_pkg::*;

	localparam int NR = NUM_REFS;
	localparam int NM = NUM_MONS;

	// Best qualified input with nonzero priority; ties go to the first input
	function automatic logic [1:0] best_ref(input logic [NR-1:0] q,
			input logic [PRIO_W-1:0] p0, input logic [PRIO_W-1:0] p1);
		logic c0;
		logic c1;
		c0 = q[0] && (p0 != PRIO_IGNORE);
		c1 = q[1] && (p1 != PRIO_IGNORE);
		if (c0 && c1) begin
			best_ref = {1'b1, (p1 < p0)};
		end else begin
			best_ref = {c0 | c1, c1 & ~c0};
		end
	endfunction

	// Reset release
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// Pin synchronisers: a change counts once stages two and three agree
	logic [1:0] pin_s1_q;
	logic [1:0] pin_s2_q;
	logic [1:0] pin_s3_q;
	logic [1:0] pin_q;
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_s1_q <= 2'h0;
			pin_s2_q <= 2'h0;
			pin_s3_q <= 2'h0;
			pin_q <= 2'h0;
		end else begin
			pin_s1_q <= {osc_in_range, man_sel_pin};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			for (int i = 0; i < 2; i++) begin
				if (pin_s2_q[i] == pin_s3_q[i]) begin
					pin_q[i] <= pin_s3_q[i];
				end
			end
		end
	end
	logic man_pin_sync;
	logic osc_range_sync;
	assign man_pin_sync = pin_q[0];
	assign osc_range_sync = pin_q[1];

	// Configuration registers
	logic [CTRL_W-1:0] ctrl_q;
	logic [7:0] prio_q;
	logic [NR*NM-1:0] mon_en_q;
	logic [VT_W-1:0] vtimer_q [NR];
	logic [SLEW_W-1:0] slew_limit_q;
	logic [SLEW_W-1:0] slew_timer_q;

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= CTRL_RESET;
			prio_q <= PRIO_RESET;
			mon_en_q <= MON_EN_RESET;
			slew_limit_q <= SLEW_LIMIT_RESET;
			slew_timer_q <= SLEW_TIMER_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: ctrl_q <= reg_wdata[CTRL_W-1:0];
				OFS_PRIO: prio_q <= reg_wdata[7:0];
				OFS_MON_EN: mon_en_q <= reg_wdata[NR*NM-1:0];
				OFS_SLEW: begin
					slew_limit_q <= reg_wdata[SLEW_W-1:0];
					slew_timer_q <= reg_wdata[SLEW_TMR_LSB +: SLEW_W];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			vtimer_q[0] <= VTIMER_RESET;
			vtimer_q[1] <= VTIMER_RESET;
		end else if (reg_wr && reg_addr == OFS_VTIMER0) begin
			vtimer_q[0] <= reg_wdata[VT_W-1:0];
		end else if (reg_wr && reg_addr == OFS_VTIMER1) begin
			vtimer_q[1] <= reg_wdata[VT_W-1:0];
		end
	end

	drsq_mode_type mode;
	logic [PRIO_W-1:0] prio0;
	logic [PRIO_W-1:0] prio1;
	logic [NR-1:0] pps_cfg;
	assign mode = drsq_mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
	assign prio0 = prio_q[0 +: PRIO_W];
	assign prio1 = prio_q[PRIO_STRIDE +: PRIO_W];
	assign pps_cfg = ctrl_q[CTRL_PPS_LSB +: NR];

	// Per-input qualification
	logic [NR*NM-1:0] flags_masked;
	logic [NR-1:0] qual_q;
	assign flags_masked = mon_flags_raw & mon_en_q;
	generate
		for (genvar g = 0; g < NR; g++) begin : g_qual
			logic [VT_W-1:0] cnt_q;
			logic any_flag;
			assign any_flag = |flags_masked[g*NM +: NM];
			always_ff @(posedge core_clk or negedge rst_n_q) begin
				if (!rst_n_q) begin
					cnt_q <= '0;
					qual_q[g] <= 1'b0;
				end else if (any_flag) begin
					cnt_q <= '0;
					qual_q[g] <= 1'b0;
				end else if (cnt_q >= vtimer_q[g]) begin
					qual_q[g] <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	endgenerate

	// Selection
	logic man_choice;
	logic [1:0] best;
	logic sel_idx_q;
	logic sel_act_q;
	logic nxt_idx;
	logic nxt_act;
	assign man_choice = ctrl_q[CTRL_MAN_PIN] ? man_pin_sync : ctrl_q[CTRL_MAN_CHOICE];
	assign best = best_ref(qual_q, prio0, prio1);

	always_comb begin
		nxt_idx = sel_idx_q;
		nxt_act = 1'b0;
		case (mode)
			MODE_AUTO_REVERT: begin
				nxt_act = best[1];
				nxt_idx = best[0];
			end
			MODE_AUTO_NONREVERT: begin
				if (sel_act_q && qual_q[sel_idx_q] &&
						(prio_q[PRIO_STRIDE*sel_idx_q +: PRIO_W] != PRIO_IGNORE)) begin
					nxt_act = 1'b1;
				end else begin
					nxt_act = best[1];
					nxt_idx = best[0];
				end
			end
			MODE_MAN_FALLBACK: begin
				if (qual_q[man_choice]) begin
					nxt_act = 1'b1;
					nxt_idx = man_choice;
				end else begin
					nxt_act = best[1];
					nxt_idx = best[0];
				end
			end
			MODE_MAN_HOLDOVER: begin
				nxt_act = qual_q[man_choice];
				nxt_idx = man_choice;
			end
			default: begin
				nxt_act = 1'b0;
			end
		endcase
	end

	// Loop state machine; mux follows the machine or the manual choice
	drsq_loop_type loop_q;
	drsq_loop_type loop_d;
	always_comb begin
		case (nxt_act)
			1'b1: loop_d = LOOP_TRACKING;
			default: loop_d = history_valid ? LOOP_HOLDOVER : LOOP_FREE_RUN;
		endcase
	end

	logic switch_evt;
	logic both_pps;
	assign both_pps = &pps_cfg;
	assign switch_evt = nxt_act && ((loop_q != LOOP_TRACKING) ||
			(nxt_idx != sel_idx_q));

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			loop_q <= LOOP_FREE_RUN;
			sel_idx_q <= 1'b0;
			sel_act_q <= 1'b0;
		end else begin
			loop_q <= loop_d;
			sel_act_q <= nxt_act;
			if (nxt_act) begin
				sel_idx_q <= nxt_idx;
			end
		end
	end

	// Hitless only when not switching 1-PPS inputs under zero-delay sync
	logic hitless_ok;
	assign hitless_ok = !(both_pps && ctrl_q[CTRL_ZDS]);

	// Phase slew: move output phase toward target by at most limit per timer period
	logic slew_q;
	logic [SLEW_W-1:0] step_cnt_q;
	logic signed [SLEW_W-1:0] phase_q;
	logic slew_start;
	logic signed [SLEW_W:0] diff;
	logic signed [SLEW_W:0] lim;
	assign slew_start = switch_evt && ctrl_q[CTRL_SLEW_EN] && hitless_ok &&
			((loop_q != LOOP_TRACKING) || !refs_freq_locked);
	assign diff = {phase_target[SLEW_W-1], phase_target} - {phase_q[SLEW_W-1], phase_q};
	assign lim = {1'b0, slew_limit_q};

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			slew_q <= 1'b0;
			step_cnt_q <= '0;
			phase_q <= '0;
		end else if (slew_start) begin
			slew_q <= 1'b1;
			step_cnt_q <= '0;
		end else if (slew_q) begin
			if (diff == '0) begin
				slew_q <= 1'b0;
			end else if (step_cnt_q + 1'b1 >= slew_timer_q) begin
				step_cnt_q <= '0;
				if (diff > lim) begin
					phase_q <= phase_q + slew_limit_q;
				end else if (diff < -lim) begin
					phase_q <= phase_q - slew_limit_q;
				end else begin
					phase_q <= phase_target;
				end
			end else begin
				step_cnt_q <= step_cnt_q + 1'b1;
			end
		end else begin
			phase_q <= phase_target;
		end
	end

	// Oscillator check
	logic osc_loss_q;
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			osc_loss_q <= 1'b1;
		end else begin
			osc_loss_q <= !osc_range_sync;
		end
	end

	// Status pins and flags
	logic [NR*NM-1:0] pins_q;
	logic [NM-1:0] sel_flags;
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pins_q <= '0;
		end else begin
			pins_q <= flags_masked;
		end
	end
	assign sel_flags = sel_act_q ? pins_q[sel_idx_q*NM +: NM] : '0;

	assign mon_status_pins = pins_q;
	assign sel_idx_pin = sel_idx_q;
	assign sel_active_pin = sel_act_q;
	assign loop_state = loop_q;
	assign ref_qualified = qual_q;
	assign osc_input_loss_flag = osc_loss_q;
	assign osc_valid = ctrl_q[CTRL_OSC_BYP] | !osc_loss_q;
	assign hitless_enable = hitless_ok;
	assign slew_active = slew_q;
	assign phase_out = phase_q;

	// Read port: data one cycle after the strobe, unmapped reads zero
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[ST_SEL_IDX] = sel_idx_q;
		status_word[ST_SEL_ACT] = sel_act_q;
		status_word[ST_LOOP_LSB +: 2] = loop_q;
		status_word[ST_QUAL_LSB +: NR] = qual_q;
		status_word[ST_FLAG_LSB +: NM] = sel_flags;
		status_word[ST_OSC_LOSS] = osc_loss_q;
		status_word[ST_SLEW_ACT] = slew_q;
		status_word[ST_HITLESS] = hitless_ok;
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL: rdata_q <= DATA_W'(ctrl_q);
				OFS_PRIO: rdata_q <= DATA_W'(prio_q);
				OFS_MON_EN: rdata_q <= DATA_W'(mon_en_q);
				OFS_VTIMER0: rdata_q <= DATA_W'(vtimer_q[0]);
				OFS_VTIMER1: rdata_q <= DATA_W'(vtimer_q[1]);
				OFS_SLEW: rdata_q <= {slew_timer_q, slew_limit_q};
				OFS_STATUS: rdata_q <= status_word;
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end
	assign reg_rdata = rdata_q;
endmodule

/* include/drsq_pkg.sv */
// Constants and types for the DPLL reference selection and qualification block
package drsq_pkg;
	localparam int NUM_REFS = 2;
	localparam int NUM_MONS = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PRIO_W = 3;
	localparam int VT_W = 24;
	localparam int SLEW_W = 16;

	// Register offsets (byte addresses, one word each)
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PRIO = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MON_EN = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_VTIMER0 = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_VTIMER1 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SLEW = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MAN_PIN = 2;
	localparam int CTRL_MAN_CHOICE = 3;
	localparam int CTRL_SLEW_EN = 4;
	localparam int CTRL_ZDS = 5;
	localparam int CTRL_OSC_BYP = 6;
	localparam int CTRL_PPS_LSB = 8;
	localparam int CTRL_W = 10;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

	// Priority register: input n priority at bits 4n+2..4n
	localparam int PRIO_STRIDE = 4;
	localparam logic [PRIO_W-1:0] PRIO_IGNORE = 3'h0;
	localparam logic [7:0] PRIO_RESET = 8'h21;

	// Monitor enables: input n uses bits 4n+3..4n (freq, miss, runt, phase-valid)
	localparam logic [NUM_REFS*NUM_MONS-1:0] MON_EN_RESET = 8'h00;
	localparam logic [VT_W-1:0] VTIMER_RESET = 24'h000400;

	// Slew register: step limit low half, step timer high half
	localparam int SLEW_TMR_LSB = 16;
	localparam logic [SLEW_W-1:0] SLEW_LIMIT_RESET = 16'h0010;
	localparam logic [SLEW_W-1:0] SLEW_TIMER_RESET = 16'h0040;

	// Status register fields
	localparam int ST_SEL_IDX = 0;
	localparam int ST_SEL_ACT = 1;
	localparam int ST_LOOP_LSB = 2;
	localparam int ST_QUAL_LSB = 4;
	localparam int ST_FLAG_LSB = 8;
	localparam int ST_OSC_LOSS = 12;
	localparam int ST_SLEW_ACT = 13;
	localparam int ST_HITLESS = 14;

	typedef enum logic [1:0] {
		MODE_AUTO_REVERT = 2'b00,
		MODE_AUTO_NONREVERT = 2'b01,
		MODE_MAN_FALLBACK = 2'b10,
		MODE_MAN_HOLDOVER = 2'b11
	} drsq_mode_type;

	typedef enum logic [1:0] {
		LOOP_FREE_RUN = 2'b00,
		LOOP_HOLDOVER = 2'b01,
		LOOP_TRACKING = 2'b10
	} drsq_loop_type;
endpackage

/* tb/drsq_ref_select_assertions.sv */
// Port-level checks for the reference selector
`timescale 1ns/1ps
module drsq_ref_select_chk (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic reg_rd,
	input wire logic [drsq_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [7:0] mon_flags_raw,
	input wire logic history_valid,
	input wire logic [7:0] mon_status_pins,
	input wire logic sel_idx_pin,
	input wire logic sel_active_pin,
	input wire logic [1:0] loop_state,
	input wire logic [1:0] ref_qualified,
	input wire logic osc_input_loss_flag,
	input wire logic osc_valid,
	input wire logic slew_active,
	input wire logic signed [drsq_pkg::SLEW_W-1:0] phase_target,
	input wire logic signed [drsq_pkg::SLEW_W-1:0] phase_out
);
	import drsq_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside answer cycle");
	flag_pins_masked_a: assert property ((mon_status_pins & ~$past(mon_flags_raw)) == '0)
		else $error("flag pin without raw flag");
	flag_drops_q0_a: assert property (|mon_status_pins[3:0] |-> !ref_qualified[0])
		else $error("first input kept qualified");
	flag_drops_q1_a: assert property (|mon_status_pins[7:4] |-> !ref_qualified[1])
		else $error("second input kept qualified");
	sel_qualified_a: assert property (sel_active_pin |->
		(sel_idx_pin ? $past(ref_qualified[1]) : $past(ref_qualified[0])))
		else $error("unqualified input selected");
	track_active_a: assert property ((loop_state == LOOP_TRACKING) == sel_active_pin)
		else $error("tracking and selection disagree");
	holdover_hist_a: assert property ($changed(loop_state) && loop_state == LOOP_HOLDOVER
		|-> $past(history_valid))
		else $error("holdover without history");
	osc_ok_a: assert property (!osc_input_loss_flag |-> osc_valid)
		else $error("oscillator invalid while in range");
	phase_follow_a: assert property (!slew_active && !$past(slew_active)
		|-> phase_out == $past(phase_target))
		else $error("phase not following target");
endmodule
bind drsq_ref_select drsq_ref_select_chk chk_u (.core_clk, .rstn, .reg_rd, .reg_rdata,
	.mon_flags_raw, .history_valid, .mon_status_pins, .sel_idx_pin, .sel_active_pin,
	.loop_state, .ref_qualified, .osc_input_loss_flag, .osc_valid, .slew_active,
	.phase_target, .phase_out);

/* tb/drsq_ref_sources.sv */
// Model of the reference sources, oscillator detector and select pin
`timescale 1ns/1ps
module drsq_ref_sources (
	input wire logic core_clk,
	input wire logic [7:0] flag_req,
	input wire logic range_req,
	input wire logic pin_req,
	output logic [7:0] mon_flags_raw = 8'h00,
	output logic osc_in_range = 1'b0,
	output logic man_sel_pin = 1'b0
);
	// Monitors live in the core domain; flags only for real faults
	always @(posedge core_clk) begin
		mon_flags_raw <= flag_req;
	end
	// Detector and pin are asynchronous, so land off the clock edge
	always @(range_req) osc_in_range <= #2 range_req;
	always @(pin_req) man_sel_pin <= #2 pin_req;
endmodule

/* tb/test_drsq_ref_select.sv */
// Self-checking bench for the reference selector
`timescale 1ns/1ps
module test_drsq_ref_select;
	import drsq_pkg::*;
	typedef struct packed {
		logic [9:0] ctrl;
		logic [7:0] prio;
		logic [7:0] en;
		logic [7:0] fl;
		logic [1:0] ph;
		logic [3:0] ex;
	} drsq_row_type;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata, rd_v;
	logic [7:0] flag_req = 8'h00;
	logic [7:0] mon_flags_raw, mon_status_pins;
	logic range_req = 1'b0;
	logic pin_req = 1'b0;
	logic history_valid = 1'b0;
	logic refs_freq_locked = 1'b0;
	logic osc_in_range, man_sel_pin, sel_idx_pin, sel_active_pin;
	logic osc_input_loss_flag, osc_valid, hitless_enable, slew_active;
	logic signed [15:0] phase_target = 16'sh0;
	logic signed [15:0] phase_out, pv;
	logic [1:0] loop_state, ref_qualified;
	logic seen, big;
	int num_errors = 0;
	int cmp_count = 0;
	// Monitor enables keep frequency and phase-valid apart
	drsq_row_type rows [15] = '{
		'{10'h000, 8'h21, 8'h77, 8'h00, 2'b00, 4'ha},
		'{10'h000, 8'h12, 8'h77, 8'h00, 2'b00, 4'he},
		'{10'h000, 8'h11, 8'h77, 8'h00, 2'b00, 4'ha},
		'{10'h000, 8'h01, 8'h77, 8'h01, 2'b01, 4'h1},
		'{10'h000, 8'h01, 8'h77, 8'h01, 2'b00, 4'h0},
		'{10'h000, 8'h21, 8'h77, 8'h02, 2'b00, 4'he},
		'{10'h000, 8'h21, 8'h76, 8'h01, 2'b00, 4'ha},
		'{10'h00a, 8'h21, 8'h77, 8'h00, 2'b00, 4'he},
		'{10'h00a, 8'h21, 8'h77, 8'h10, 2'b01, 4'ha},
		'{10'h00a, 8'h21, 8'h77, 8'h11, 2'b01, 4'h1},
		'{10'h00b, 8'h21, 8'h77, 8'h10, 2'b01, 4'h1},
		'{10'h00b, 8'h21, 8'h77, 8'h00, 2'b00, 4'he},
		'{10'h007, 8'h21, 8'h77, 8'h00, 2'b00, 4'ha},
		'{10'h007, 8'h21, 8'h77, 8'h00, 2'b10, 4'he},
		'{10'h00a, 8'h01, 8'h77, 8'h00, 2'b00, 4'he}
	};
	logic [31:0] rst_v [8] = '{32'(CTRL_RESET), 32'(PRIO_RESET), 32'(MON_EN_RESET),
		32'(VTIMER_RESET), 32'(VTIMER_RESET), {SLEW_TIMER_RESET, SLEW_LIMIT_RESET},
		32'h5000, 32'h0};
	drsq_ref_select dut_u (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .mon_flags_raw, .osc_in_range, .man_sel_pin, .history_valid,
		.refs_freq_locked, .phase_target, .mon_status_pins, .sel_idx_pin, .sel_active_pin,
		.loop_state, .ref_qualified, .osc_input_loss_flag, .osc_valid, .hitless_enable,
		.slew_active, .phase_out);
	drsq_ref_sources src_u (.core_clk, .flag_req, .range_req, .pin_req, .mon_flags_raw,
		.osc_in_range, .man_sel_pin);
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
		cmp_count++;
		if (seen_v !== exp_v) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen_v, exp_v);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask
	task automatic do_reset;
		rstn <= 1'b0;
		cyc(12);
		rstn <= 1'b1;
		cyc(3);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		do_reset;
		wr(OFS_VTIMER0, 32'h4);
		wr(OFS_VTIMER1, 32'h4);
		foreach (rows[i]) begin
			wr(OFS_CTRL, 32'(rows[i].ctrl));
			wr(OFS_PRIO, 32'(rows[i].prio));
			wr(OFS_MON_EN, 32'(rows[i].en));
			flag_req <= rows[i].fl;
			{pin_req, history_valid} <= rows[i].ph;
			cyc(14);
			chk(sel_active_pin, rows[i].ex[3]);
			chk(loop_state, rows[i].ex[1:0]);
			chk(mon_status_pins, rows[i].fl & rows[i].en);
			rd(OFS_STATUS);
			chk(rd_v[3:1], {rows[i].ex[1:0], rows[i].ex[3]});
			if (rows[i].ex[3]) begin
				chk(sel_idx_pin, rows[i].ex[2]);
				chk(rd_v[0], rows[i].ex[2]);
				chk(rd_v[11:8], 4'h0);
			end
		end
		$display("table done");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_PRIO, 32'h21);
		wr(OFS_VTIMER1, 32'h20);
		flag_req <= 8'h11;
		cyc(3);
		chk(ref_qualified, 2'b00);
		flag_req <= 8'h00;
		cyc(3);
		chk(ref_qualified, 2'b00);
		flag_req <= 8'h01;
		cyc(1);
		flag_req <= 8'h00;
		cyc(4);
		chk(ref_qualified, 2'b00);
		cyc(6);
		chk(ref_qualified, 2'b01);
		cyc(30);
		chk(ref_qualified, 2'b11);
		wr(OFS_VTIMER1, 32'h4);
		$display("qualification done");
		wr(OFS_CTRL, 32'h1);
		flag_req <= 8'h01;
		cyc(14);
		chk(sel_idx_pin, 1'b1);
		flag_req <= 8'h00;
		cyc(14);
		chk(sel_idx_pin, 1'b1);
		flag_req <= 8'h10;
		cyc(14);
		chk(sel_idx_pin, 1'b0);
		$display("non-revertive done");
		range_req <= 1'b1;
		cyc(8);
		chk(osc_input_loss_flag, 1'b0);
		chk(osc_valid, 1'b1);
		range_req <= 1'b0;
		cyc(8);
		chk(osc_input_loss_flag, 1'b1);
		chk(osc_valid, 1'b0);
		wr(OFS_CTRL, 32'h40);
		cyc(2);
		chk(osc_valid, 1'b1);
		chk(osc_input_loss_flag, 1'b1);
		wr(OFS_MON_EN, 32'h88);
		wr(OFS_CTRL, 32'h320);
		cyc(1);
		chk(hitless_enable, 1'b0);
		wr(OFS_CTRL, 32'h120);
		cyc(1);
		chk(hitless_enable, 1'b1);
		wr(OFS_MON_EN, 32'h77);
		$display("oscillator and hitless done");
		wr(OFS_SLEW, 32'h00010002);
		wr(OFS_CTRL, 32'h10);
		flag_req <= 8'h00;
		cyc(14);
		// Target moves just as the switch lands, so only slewing can hide it
		flag_req <= 8'h01;
		cyc(2);
		phase_target <= 16'sh0040;
		seen = 1'b0;
		big = 1'b0;
		repeat (300) begin
			pv = phase_out;
			cyc(1);
			seen |= slew_active;
			if (phase_out - pv > 2 || pv - phase_out > 2) big = 1'b1;
		end
		chk(seen, 1'b1);
		chk(big, 1'b0);
		chk(phase_out, 16'h0040);
		// Switch back between locked references must not slew
		refs_freq_locked <= 1'b1;
		flag_req <= 8'h00;
		seen = 1'b0;
		repeat (14) begin
			cyc(1);
			seen |= slew_active;
		end
		chk(seen, 1'b0);
		chk(sel_idx_pin, 1'b0);
		$display("slew done");
		phase_target <= 16'sh0;
		flag_req <= 8'h00;
		cyc(2);
		do_reset;
		chk(ref_qualified, 2'b00);
		chk(loop_state, LOOP_FREE_RUN);
		for (int i = 0; i < 8; i++) begin
			rd(8'(4 * i));
			chk(rd_v, rst_v[i]);
		end
		wr(OFS_STATUS, 32'hffffffff);
		wr(8'h1c, 32'hffffffff);
		rd(OFS_STATUS);
		chk(rd_v, 32'h5000);
		rd(8'h1c);
		chk(rd_v, 32'h0);
		$display("reset values done");
		results;
	end
endmodule
